/* File: common/mtc_pkg.sv */
// Constants and types shared by the five-channel timer core.
package mtc_pkg;
    localparam int NCH = 5;
    // Channel c registers sit at c*16 + offset.
    localparam logic [3:0] OFF_CTRL  = 4'h0;
    localparam logic [3:0] OFF_PINF  = 4'h1;
    localparam logic [3:0] OFF_IEN   = 4'h2;
    localparam logic [3:0] OFF_FLAG  = 4'h3;
    localparam logic [3:0] OFF_W16LO = 4'h4;
    localparam logic [3:0] OFF_W16HI = 4'hD;
    // Shared registers.
    localparam logic [6:0] ADR_START = 7'h50;
    localparam logic [6:0] ADR_SYNC  = 7'h51;
    localparam logic [6:0] ADR_MODE  = 7'h52;
    localparam logic [6:0] ADR_BUF   = 7'h53;
    // Reset values and reserved-bit read patterns.
    localparam logic [7:0] RST_CTRL  = 8'h80;
    localparam logic [7:0] RST_PINF  = 8'h88;
    localparam logic [7:0] RST_IEN   = 8'hF8;
    localparam logic [7:0] RST_FLAG  = 8'hF8;
    localparam logic [7:0] RESV_HI5  = 8'hF8;
    localparam logic [7:0] RESV_SHR  = 8'hE0;
    // Flag and enable bit positions.
    localparam int BIT_A = 0;
    localparam int BIT_B = 1;
    localparam int BIT_W = 2;
    // Clear select codes.
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A    = 2'h1;
    localparam logic [1:0] CLR_B    = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    // Phase counting enable bit in the mode register; channel that owns it.
    localparam int MODE_PHASE = 6;
    localparam int PHASE_CH   = 2;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        word;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } mtc_bus_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LOW  = 2'b10
    } mtc_acc_e;
endpackage

/* File: verilog/mtc_core.sv */
// Five-channel 16-bit timer counter core with its CPU register port.
`timescale 1ns/1ps
`default_nettype none
module mtc_core
    import mtc_pkg::*;
(
    // Clock and reset.
    input  wire logic           i_clk_sys,
    input  wire logic           i_reset,
    input  wire logic           i_standby,
    // CPU register port.
    input  wire mtc_bus_s       i_bus,
    output logic         [15:0] o_bus_rdata,
    output logic                o_bus_ack,
    // Pins.
    input  wire logic     [3:0] i_ext_clk,
    input  wire logic [NCH-1:0] i_cap_a,
    input  wire logic [NCH-1:0] i_cap_b,
    output logic      [NCH-1:0] o_pin_a,
    output logic      [NCH-1:0] o_pin_b,
    // Interrupt requests.
    output logic      [NCH-1:0] o_match_irq_a,
    output logic      [NCH-1:0] o_match_irq_b,
    output logic      [NCH-1:0] o_wrap_irq
);
    logic [15:0] cnt_r [NCH];
    logic [15:0] gra_r [NCH];
    logic [15:0] grb_r [NCH];
    logic [15:0] bra_r [NCH];
    logic [15:0] brb_r [NCH];
    logic [7:0]  tcr_r [NCH];
    logic [7:0]  pin_function_register_r [NCH];
    logic [2:0]  ien_r [NCH];
    logic [2:0]  flg_r [NCH];
    logic [2:0]  arm_r [NCH];
    logic [NCH-1:0] timer_start_register_r, tsnc_r, pwm_r, buf_r;
    logic           phase_r;
    logic [2:0]     pre_r;
    logic [3:0]     ext_q_r;
    logic [NCH-1:0] capa_q_r, capb_q_r;
    mtc_acc_e       st_r;
    logic [6:0]     p2_addr_r;
    logic [7:0]     p2_lo_r, rd_hi_r;
    logic           p2_wr_r, p2_rd_r;

    // Access decode; a split word on an 8-bit register runs its low byte next cycle.
    wire        p2      = (st_r == ST_LOW);
    wire        take    = !p2 && (i_bus.rd || i_bus.wr);
    wire [6:0]  ea      = p2 ? p2_addr_r : i_bus.addr;
    wire        ewr     = p2 ? p2_wr_r : (take && i_bus.wr);
    wire        erd     = p2 ? p2_rd_r : (take && i_bus.rd);
    wire [2:0]  ech     = ea[6:4];
    wire [3:0]  off     = ea[3:0];
    wire        inch    = (ech < 3'(NCH));
    wire        is16    = inch && off >= OFF_W16LO && off <= OFF_W16HI;
    wire        eword   = !p2 && i_bus.word && is16;
    wire        split   = take && i_bus.word && !is16;
    wire [7:0]  bd      = p2 ? p2_lo_r : (split ? i_bus.wdata[15:8] : i_bus.wdata[7:0]);
    wire [15:0] wv      = eword ? i_bus.wdata : {bd, bd};
    wire        be_hi   = eword || !off[0];
    wire        be_lo   = eword || off[0];
    wire [2:0]  idx16   = 3'((off - OFF_W16LO) >> 1);
    wire [2:0]  chs     = inch ? ech : 3'h0;

    function automatic logic [15:0] merge(input logic [15:0] o, input logic h, input logic l,
                                          input logic [15:0] v);
        merge = {h ? v[15:8] : o[15:8], l ? v[7:0] : o[7:0]};
    endfunction

    wire [15:0] pval = merge(cnt_r[chs], be_hi, be_lo, wv);
    logic [NCH-1:0] cnt_wr, clr_own, evt_a, evt_b, cmp_a, cmp_b, ctick, up, presetv, clrv;
    wire            sync_pre = |(cnt_wr & tsnc_r);
    wire            sync_clr = |(clr_own & tsnc_r);
    logic [7:0]     rb8 [NCH];
    logic [15:0]    rw16 [NCH];

    // Count clock ticks for the internal divisions.
    wire [3:0] itick = {pre_r == 3'h7, pre_r[1:0] == 2'h3, pre_r[0], 1'b1};
    wire [3:0] erise = i_ext_clk & ~ext_q_r;
    wire [3:0] efall = ~i_ext_clk & ext_q_r;

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            wire       sel   = inch && ech == 3'(c);
            wire       w8    = ewr && sel && !is16;
            wire       w16   = ewr && sel && is16;
            wire [2:0] ps    = tcr_r[c][2:0];
            wire [1:0] eg    = tcr_r[c][4:3];
            wire [1:0] cs    = tcr_r[c][6:5];
            wire [1:0] ep    = ps[1:0];
            wire       etk   = eg == 2'h0 ? erise[ep] : eg == 2'h1 ? efall[ep] : (erise[ep] | efall[ep]);
            wire       ph    = (c == PHASE_CH) && phase_r;
            wire       phtk  = (i_ext_clk[0] ^ ext_q_r[0]) || (i_ext_clk[1] ^ ext_q_r[1]);
            wire       tick  = ph ? phtk : (ps[2] ? etk : itick[ps[1:0]]);
            wire       cpa   = pin_function_register_r[c][2] && !pwm_r[c];
            wire       cpb   = pin_function_register_r[c][6] && !pwm_r[c];
            wire [1:0] ia    = pin_function_register_r[c][1:0];
            wire [1:0] ib    = pin_function_register_r[c][5:4];
            wire       ra    = i_cap_a[c] && !capa_q_r[c];
            wire       fa    = !i_cap_a[c] && capa_q_r[c];
            wire       rb    = i_cap_b[c] && !capb_q_r[c];
            wire       fb    = !i_cap_b[c] && capb_q_r[c];
            wire       capa  = cpa && (ia == 2'h0 ? ra : ia == 2'h1 ? fa : (ra | fa));
            wire       capb  = cpb && (ib == 2'h0 ? rb : ib == 2'h1 ? fb : (rb | fb));
            wire       wrap  = ctick[c] && (up[c] ? cnt_r[c] == CNT_MAX : cnt_r[c] == 16'h0000);
            wire       tsrw  = w8 && off == OFF_FLAG;
            wire [2:0] fset  = {wrap, evt_b[c], evt_a[c]};
            wire [2:0] fclr  = tsrw ? (arm_r[c] & ~bd[2:0]) : 3'h0;
            wire [15:0] cntn = cnt_r[c] + (up[c] ? 16'h0001 : CNT_MAX);

            assign ctick[c]   = timer_start_register_r[c] && tick;
            assign up[c]      = !ph || (i_ext_clk[0] ^ ext_q_r[1]);
            assign cmp_a[c]   = ctick[c] && !cpa && cnt_r[c] == gra_r[c];
            assign cmp_b[c]   = ctick[c] && !cpb && cnt_r[c] == grb_r[c];
            assign evt_a[c]   = cmp_a[c] || capa;
            assign evt_b[c]   = cmp_b[c] || capb;
            assign clr_own[c] = (cs == CLR_A && evt_a[c]) || (cs == CLR_B && evt_b[c]);
            assign clrv[c]    = clr_own[c] || (tsnc_r[c] && cs == CLR_SYNC && sync_clr);
            assign cnt_wr[c]  = w16 && idx16 == 3'h0;
            assign presetv[c] = cnt_wr[c] || (tsnc_r[c] && sync_pre);
            assign rw16[c]    = idx16 == 3'h0 ? cnt_r[c] : idx16 == 3'h1 ? gra_r[c] :
                                idx16 == 3'h2 ? grb_r[c] : idx16 == 3'h3 ? bra_r[c] : brb_r[c];
            assign rb8[c]     = off == OFF_CTRL ? tcr_r[c] : off == OFF_PINF ? pin_function_register_r[c] :
                                off == OFF_IEN ? (RESV_HI5 | 8'(ien_r[c])) :
                                off == OFF_FLAG ? (RESV_HI5 | 8'(flg_r[c])) :
                                (off[0] ? rw16[c][7:0] : rw16[c][15:8]);

            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    cnt_r[c]  <= 16'h0000;
                    tcr_r[c]  <= RST_CTRL;
                    pin_function_register_r[c] <= RST_PINF;
                    ien_r[c]  <= RST_IEN[2:0];
                    flg_r[c]  <= RST_FLAG[2:0];
                    arm_r[c]  <= 3'h0;
                end else if (i_standby) begin
                    cnt_r[c]  <= 16'h0000;
                    tcr_r[c]  <= RST_CTRL;
                    pin_function_register_r[c] <= RST_PINF;
                    ien_r[c]  <= RST_IEN[2:0];
                    flg_r[c]  <= RST_FLAG[2:0];
                    arm_r[c]  <= 3'h0;
                end else begin
                    if (presetv[c]) cnt_r[c] <= pval;
                    else if (clrv[c]) cnt_r[c] <= 16'h0000;
                    else if (ctick[c]) cnt_r[c] <= cntn;
                    if (w8 && off == OFF_CTRL) tcr_r[c] <= 8'h80 | bd;
                    if (w8 && off == OFF_PINF) pin_function_register_r[c] <= 8'h88 | bd;
                    if (w8 && off == OFF_IEN) ien_r[c] <= bd[2:0];
                    // Set wins over a clear landing in the same cycle.
                    flg_r[c] <= (flg_r[c] & ~fclr) | fset;
                    if (tsrw) arm_r[c] <= 3'h0;
                    else if (erd && sel && off == OFF_FLAG) arm_r[c] <= flg_r[c];
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    gra_r[c] <= CNT_MAX;
                    grb_r[c] <= CNT_MAX;
                    bra_r[c] <= CNT_MAX;
                    brb_r[c] <= CNT_MAX;
                    o_pin_a[c] <= 1'b0;
                    o_pin_b[c] <= 1'b0;
                end else if (i_standby) begin
                    gra_r[c] <= CNT_MAX;
                    grb_r[c] <= CNT_MAX;
                    bra_r[c] <= CNT_MAX;
                    brb_r[c] <= CNT_MAX;
                    o_pin_a[c] <= 1'b0;
                    o_pin_b[c] <= 1'b0;
                end else begin
                    if (capa) gra_r[c] <= cnt_r[c];
                    else if (cmp_a[c] && buf_r[c]) gra_r[c] <= bra_r[c];
                    else if (w16 && idx16 == 3'h1) gra_r[c] <= merge(gra_r[c], be_hi, be_lo, wv);
                    if (capb) grb_r[c] <= cnt_r[c];
                    else if (cmp_b[c] && buf_r[c]) grb_r[c] <= brb_r[c];
                    else if (w16 && idx16 == 3'h2) grb_r[c] <= merge(grb_r[c], be_hi, be_lo, wv);
                    if (capa && buf_r[c]) bra_r[c] <= gra_r[c];
                    else if (w16 && idx16 == 3'h3) bra_r[c] <= merge(bra_r[c], be_hi, be_lo, wv);
                    if (capb && buf_r[c]) brb_r[c] <= grb_r[c];
                    else if (w16 && idx16 == 3'h4) brb_r[c] <= merge(brb_r[c], be_hi, be_lo, wv);
                    // Equal A and B leave the PWM level unchanged.
                    if (pwm_r[c]) begin
                        if (cmp_a[c] && !cmp_b[c]) o_pin_a[c] <= 1'b1;
                        else if (cmp_b[c] && !cmp_a[c]) o_pin_a[c] <= 1'b0;
                    end else if (cmp_a[c] && ia != 2'h0) begin
                        o_pin_a[c] <= ia == 2'h2 || (ia == 2'h3 && (c == PHASE_CH || !o_pin_a[c]));
                    end
                    if (!pwm_r[c] && cmp_b[c] && ib != 2'h0) begin
                        o_pin_b[c] <= ib == 2'h2 || (ib == 2'h3 && (c == PHASE_CH || !o_pin_b[c]));
                    end
                end
            end
        end
    endgenerate

    // Shared registers, bus sequencing and request outputs.
    wire [7:0] rsh = ea == ADR_START ? (RESV_SHR | 8'(timer_start_register_r)) : ea == ADR_SYNC ? (RESV_SHR | 8'(tsnc_r)) :
                     ea == ADR_MODE ? {1'b1, phase_r, 1'b0, pwm_r} : ea == ADR_BUF ? (RESV_SHR | 8'(buf_r)) : 8'h00;
    wire [7:0] rbyte = inch ? rb8[chs] : rsh;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            {timer_start_register_r, tsnc_r, pwm_r, buf_r} <= '0;
            phase_r <= 1'b0;
        end else if (i_standby) begin
            {timer_start_register_r, tsnc_r, pwm_r, buf_r} <= '0;
            phase_r <= 1'b0;
        end else if (ewr && !inch) begin
            if (ea == ADR_START) timer_start_register_r <= bd[NCH-1:0];
            if (ea == ADR_SYNC) tsnc_r <= bd[NCH-1:0];
            if (ea == ADR_MODE) {phase_r, pwm_r} <= {bd[MODE_PHASE], bd[NCH-1:0]};
            if (ea == ADR_BUF) buf_r <= bd[NCH-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            st_r        <= ST_IDLE;
            p2_addr_r   <= 7'h00;
            p2_lo_r     <= 8'h00;
            p2_wr_r     <= 1'b0;
            p2_rd_r     <= 1'b0;
            rd_hi_r     <= 8'h00;
            o_bus_ack   <= 1'b0;
            o_bus_rdata <= 16'h0000;
        end else begin
            st_r        <= split ? ST_LOW : ST_IDLE;
            p2_addr_r   <= 7'(ea + 7'h01);
            p2_lo_r     <= i_bus.wdata[7:0];
            p2_wr_r     <= take && i_bus.wr;
            p2_rd_r     <= take && i_bus.rd;
            rd_hi_r     <= rbyte;
            o_bus_ack   <= (take && !split) || p2;
            if (erd) o_bus_rdata <= eword ? rw16[chs] : (p2 ? {rd_hi_r, rbyte} : {8'h00, rbyte});
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            pre_r    <= 3'h0;
            ext_q_r  <= 4'h0;
            capa_q_r <= '0;
            capb_q_r <= '0;
            o_match_irq_a <= '0;
            o_match_irq_b <= '0;
            o_wrap_irq    <= '0;
        end else begin
            pre_r    <= pre_r + 3'h1;
            ext_q_r  <= i_ext_clk;
            capa_q_r <= i_cap_a;
            capb_q_r <= i_cap_b;
            for (int k = 0; k < NCH; k++) begin
                o_match_irq_a[k] <= flg_r[k][BIT_A] && ien_r[k][BIT_A];
                o_match_irq_b[k] <= flg_r[k][BIT_B] && ien_r[k][BIT_B];
                o_wrap_irq[k]    <= flg_r[k][BIT_W] && ien_r[k][BIT_W];
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset || i_standby);
    wire wr0f = ewr && ech == 3'h0 && off == OFF_FLAG && !is16;
    // Standby also drops the flag, one edge before this check can see it fall.
    flag_clear_a: assert property ($fell(flg_r[0][0]) |-> $past(wr0f && !bd[0] && arm_r[0][0]) || $past(i_standby))
        else $error("flag A cleared without read then zero write");
    match_set_a: assert property (evt_a[0] |=> flg_r[0][0] ##1 flg_r[0][0] || $past(wr0f))
        else $error("flag A not set after match or capture");
    ien_resv_a: assert property (erd && !split && !p2 && ea == 7'h02 |=> o_bus_rdata[7:3] == 5'h1F)
        else $error("enable reserved bits not one");
    wrap_irq_a: assert property (flg_r[0][2] && ien_r[0][2] |=> o_wrap_irq[0])
        else $error("wrap request missing");
    irq_b_a: assert property (!ien_r[2][1] |=> !o_match_irq_b[2])
        else $error("B request while disabled");
    irq_a_a: assert property (o_match_irq_a[3] |-> $past(flg_r[3][0] && ien_r[3][0]))
        else $error("A request without flag and enable");
    run_gate_a: assert property (!timer_start_register_r[0] && !presetv[0] && !clrv[0] |=> $stable(cnt_r[0]))
        else $error("counter moved while stopped");
    wrap_set_a: assert property (ctick[0] && cnt_r[0] == CNT_MAX && !presetv[0] && !clrv[0]
        |=> cnt_r[0] == 16'h0000 && flg_r[0][2])
        else $error("wrap did not set flag or zero counter");
    sync_pre_a: assert property (cnt_wr[0] && tsnc_r[0] && tsnc_r[1] |=> cnt_r[1] == cnt_r[0])
        else $error("synchronised preset mismatch");
    pwm_high_a: assert property (pwm_r[4] && cmp_a[4] && !cmp_b[4] |=> o_pin_a[4])
        else $error("PWM pin not high after match A");
    split_ack_a: assert property (split |=> !o_bus_ack ##1 o_bus_ack)
        else $error("split word ack timing wrong");
    cv_wrap: cover property (ctick[0] && cnt_r[0] == CNT_MAX);
    cv_period: cover property (clr_own[0] ##1 cnt_r[0] == 16'h0000);
    cv_split: cover property (split);
    cv_pwm: cover property (pwm_r[4] && cmp_b[4]);
endmodule
`default_nettype wire

/* File: testbench/mtc_cpu_model.sv */
// CPU-side bus master model that issues single register requests to the timer.
`timescale 1ns/1ps
`default_nettype none
module mtc_cpu_model
    import mtc_pkg::*;
(
    // Clock.
    input  wire logic        i_clk_sys,
    // Register port of the timer.
    output var  mtc_bus_s    o_bus,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_ack
);
    initial o_bus = '0;

    // One request pulse, then wait for its ack; a split word waits a cycle longer.
    task automatic xfer(input logic wr, input logic word, input logic [6:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata);
        int n;
        @(posedge i_clk_sys);
        #1;
        o_bus = '{rd: ~wr, wr: wr, word: word, addr: addr, wdata: wdata};
        @(posedge i_clk_sys);
        #1;
        // Released fields carry the inverse so stale values are never read as valid.
        o_bus = '{rd: 1'b0, wr: 1'b0, word: ~word, addr: ~addr, wdata: ~wdata};
        n = 0;
        while (i_ack !== 1'b1 && n < 4) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        rdata = (i_ack === 1'b1) ? i_rdata : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the five-channel timer core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top
    import mtc_pkg::*;
;
    logic           i_clk_sys;
    logic           i_reset;
    logic           i_standby;
    mtc_bus_s       bus;
    logic    [15:0] rdata;
    logic           ack;
    logic     [3:0] i_ext_clk;
    logic [NCH-1:0] cap_a;
    logic [NCH-1:0] cap_b;
    logic [NCH-1:0] pin_a;
    logic [NCH-1:0] pin_b;
    logic [NCH-1:0] irq_a;
    logic [NCH-1:0] irq_b;
    logic [NCH-1:0] irq_w;
    logic    [15:0] rv;
    int             fail_count;
    int             cmp_count;
    int             cyc;
    int             hi;

    mtc_core mtc_core_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_standby(i_standby), .i_bus(bus),
        .o_bus_rdata(rdata), .o_bus_ack(ack), .i_ext_clk(i_ext_clk), .i_cap_a(cap_a), .i_cap_b(cap_b),
        .o_pin_a(pin_a), .o_pin_b(pin_b), .o_match_irq_a(irq_a), .o_match_irq_b(irq_b), .o_wrap_irq(irq_w));
    mtc_cpu_model mtc_cpu_model_inst (.i_clk_sys(i_clk_sys), .o_bus(bus), .i_rdata(rdata), .i_ack(ack));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A hang is cut short well above the few hundred cycles the tests need.
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic w);
        logic [15:0] x;
        mtc_cpu_model_inst.xfer(1'b1, w, a, d, x);
    endtask
    task automatic rd(input logic [6:0] a, input logic w);
        mtc_cpu_model_inst.xfer(1'b0, w, a, 16'h0000, rv);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic pulse_cap(input int c);
        cap_a[c] = 1'b1;
        cap_b[c] = 1'b1;
        tick(3);
        cap_a[c] = 1'b0;
        cap_b[c] = 1'b0;
        tick(3);
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, fail_count);
    endtask

    initial begin
        i_reset = 1'b1;
        i_standby = 1'b0;
        i_ext_clk = 4'h0;
        cap_a = 5'h00;
        cap_b = 5'h00;
        fail_count = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (8) @(posedge i_clk_sys);
        #1;
        i_reset = 1'b0;
        rd(7'h02, 1'b0); `CHK("enable reset", 8'hF8, rv[7:0])
        rd(7'h03, 1'b0); `CHK("flags reset", 8'hF8, rv[7:0])
        rd(7'h00, 1'b0); `CHK("ctrl reset", 8'h80, rv[7:0])
        done("reset");
        wr(7'h02, 16'h0005, 1'b0); rd(7'h02, 1'b0); `CHK("enable rw", 8'hFD, rv[7:0])
        i_standby = 1'b1;
        tick(1);
        i_standby = 1'b0;
        rd(7'h02, 1'b0); `CHK("enable standby", 8'hF8, rv[7:0])
        wr(7'h02, 16'h0007, 1'b0); rd(7'h02, 1'b1); `CHK("split word read", 16'hFFF8, rv)
        wr(7'h02, 16'h0000, 1'b0);
        done("enable");
        wr(7'h51, 16'h0003, 1'b0);
        wr(7'h04, 16'h1234, 1'b1); rd(7'h14, 1'b1); `CHK("sync preset", 16'h1234, rv)
        rd(7'h05, 1'b0); `CHK("low byte", 8'h34, rv[7:0])
        rd(7'h14, 1'b0); `CHK("high byte", 8'h12, rv[7:0])
        wr(7'h15, 16'h0056, 1'b0); rd(7'h14, 1'b1); `CHK("byte write", 16'h1256, rv)
        wr(7'h51, 16'h0000, 1'b0);
        done("access");
        wr(7'h02, 16'h0004, 1'b0);
        wr(7'h04, 16'hFFF0, 1'b1);
        tick(20);
        rd(7'h04, 1'b1); `CHK("stopped counter", 16'hFFF0, rv)
        wr(7'h50, 16'h0001, 1'b0);
        tick(40);
        wr(7'h50, 16'h0000, 1'b0);
        rd(7'h04, 1'b1); `CHK("wrap continues", 1'b1, (rv > 16'h0010 && rv < 16'h0040))
        tick(2); `CHK("wrap irq", 1'b1, irq_w[0])
        `CHK("match irq b masked", 1'b0, irq_b[0])
        wr(7'h02, 16'h0000, 1'b0); tick(2); `CHK("wrap irq masked", 1'b0, irq_w[0])
        wr(7'h02, 16'h0006, 1'b0); tick(2); `CHK("match irq b", 1'b1, irq_b[0])
        wr(7'h03, 16'h0000, 1'b0); rd(7'h03, 1'b0); `CHK("clear without read", 8'hFF, rv[7:0])
        wr(7'h03, 16'h0000, 1'b0); rd(7'h03, 1'b0); `CHK("clear after read", 8'hF8, rv[7:0])
        tick(2); `CHK("wrap irq drops", 1'b0, irq_w[0])
        `CHK("match irq b drops", 1'b0, irq_b[0])
        done("wrap");
        wr(7'h30, 16'h0020, 1'b0);
        wr(7'h31, 16'h0020, 1'b0);
        wr(7'h36, 16'h0010, 1'b1);
        wr(7'h38, 16'h0008, 1'b1);
        wr(7'h32, 16'h0001, 1'b0);
        wr(7'h50, 16'h0008, 1'b0);
        tick(50);
        wr(7'h50, 16'h0000, 1'b0);
        rd(7'h33, 1'b0); `CHK("match flags", 8'hFB, rv[7:0])
        `CHK("pin b level", 1'b1, pin_b[3])
        rd(7'h34, 1'b1); `CHK("period bound", 1'b1, (rv <= 16'h0010))
        tick(2); `CHK("match irq a", 1'b1, irq_a[3])
        wr(7'h32, 16'h0000, 1'b0); tick(2); `CHK("match irq a masked", 1'b0, irq_a[3])
        done("periodic");
        wr(7'h3A, 16'h0006, 1'b1);
        wr(7'h53, 16'h0008, 1'b0);
        wr(7'h50, 16'h0008, 1'b0);
        tick(30);
        wr(7'h50, 16'h0000, 1'b0);
        wr(7'h53, 16'h0000, 1'b0);
        rd(7'h36, 1'b1); `CHK("buffered compare", 16'h0006, rv)
        done("buffer");
        wr(7'h11, 16'h00CC, 1'b0);
        wr(7'h14, 16'h00AB, 1'b1);
        pulse_cap(1);
        rd(7'h16, 1'b1); `CHK("capture value", 16'h00AB, rv)
        rd(7'h13, 1'b0); `CHK("capture flag", 8'hFB, rv[7:0])
        wr(7'h53, 16'h0002, 1'b0);
        wr(7'h14, 16'h00CD, 1'b1);
        pulse_cap(1);
        rd(7'h16, 1'b1); `CHK("buffered capture", 16'h00CD, rv)
        rd(7'h1A, 1'b1); `CHK("buffer shifted", 16'h00AB, rv)
        rd(7'h1C, 1'b1); `CHK("buffer b shifted", 16'h00AB, rv)
        done("capture");
        wr(7'h51, 16'h0003, 1'b0);
        wr(7'h00, 16'h0020, 1'b0);
        wr(7'h10, 16'h0060, 1'b0);
        wr(7'h06, 16'h0005, 1'b1);
        wr(7'h04, 16'h0000, 1'b1);
        wr(7'h50, 16'h0003, 1'b0);
        tick(20);
        wr(7'h50, 16'h0000, 1'b0);
        wr(7'h51, 16'h0000, 1'b0);
        rd(7'h14, 1'b1); `CHK("sync clear", 1'b1, (rv <= 16'h0005))
        done("sync clear");
        wr(7'h20, 16'h0003, 1'b0);
        wr(7'h50, 16'h0004, 1'b0);
        tick(80);
        wr(7'h50, 16'h0000, 1'b0);
        rd(7'h24, 1'b1); `CHK("divide by 8", 1'b1, (rv >= 16'h0009 && rv <= 16'h000B))
        wr(7'h24, 16'h0000, 1'b1);
        wr(7'h20, 16'h0004, 1'b0);
        wr(7'h50, 16'h0004, 1'b0);
        repeat (5) begin
            i_ext_clk[0] = 1'b1;
            tick(2);
            i_ext_clk[0] = 1'b0;
            tick(2);
        end
        wr(7'h50, 16'h0000, 1'b0);
        rd(7'h24, 1'b1); `CHK("pin clock", 16'h0005, rv)
        wr(7'h24, 16'h0000, 1'b1);
        wr(7'h52, 16'h0040, 1'b0);
        wr(7'h50, 16'h0004, 1'b0);
        // Pin a leads pin b through one full cycle, four up counts.
        i_ext_clk[0] = 1'b1;
        tick(2);
        i_ext_clk[1] = 1'b1;
        tick(2);
        i_ext_clk[0] = 1'b0;
        tick(2);
        i_ext_clk[1] = 1'b0;
        tick(2);
        wr(7'h50, 16'h0000, 1'b0);
        wr(7'h52, 16'h0000, 1'b0);
        rd(7'h24, 1'b1); `CHK("phase up count", 16'h0004, rv)
        done("clock source");
        wr(7'h40, 16'h0040, 1'b0);
        wr(7'h46, 16'h0004, 1'b1);
        wr(7'h48, 16'h0008, 1'b1);
        wr(7'h41, 16'h008C, 1'b0);
        wr(7'h52, 16'h0010, 1'b0);
        wr(7'h50, 16'h0010, 1'b0);
        hi = 0;
        repeat (45) begin
            tick(1);
            hi += (pin_a[4] === 1'b1) ? 1 : 0;
        end
        wr(7'h50, 16'h0000, 1'b0);
        `CHK("pwm duty", 1'b1, (hi > 10 && hi < 30))
        done("pwm");
        stop_test();
    end
endmodule
`default_nettype wire
